/* verilog/ahs_sequencer.sv */
// Homing sequencer top: command word, step table, speed command, actual position
`timescale 1ns/1ps
`include "ahs_params.svh"
module ahs_sequencer #(
  parameter int MECH_PERSIST_CYC = `AHS_MECH_PERSIST_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] drive_command_word,
  output logic [15:0] drive_status_word,
  input wire logic [7:0] homing_method_select,
  input wire logic homing_offset_kind,
  input wire logic [31:0] home_position_offset,
  input wire ahs_pkg::ahs_motion_cfg_t motion_cfg,
  input wire ahs_pkg::ahs_pins_t pins,
  input wire logic torque_at_limit,
  input wire logic speed_near_zero,
  input wire logic [15:0] enc_delta,
  output logic [31:0] actual_position,
  output logic [31:0] speed_cmd,
  output logic [31:0] accel_cmd,
  output logic homing_active
);

  function automatic ahs_pkg::ahs_step_t mk(input logic fwd, input logic fast,
                                            input ahs_pkg::ahs_ev_t ev, input logic last);
    ahs_pkg::ahs_step_t s;
    s.fwd = fwd;
    s.fast = fast;
    s.ev = ev;
    s.last = last;
    return s;
  endfunction : mk

  // Step table: direction, speed and terminating event of each leg
  function automatic ahs_pkg::ahs_step_t step_of(input logic [7:0] m,
                                                 input ahs_pkg::ahs_branch_t br,
                                                 input logic [1:0] i);
    ahs_pkg::ahs_step_t s;
    logic [3:0] k;
    s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_Z, 1'b1);
    k = {br, i};
    case (m)
      `AHS_M28: begin
        case (k)
          4'h0: s = mk(1'b0, 1'b1, ahs_pkg::AHS_EV_RISE, 1'b0); // R1
          4'h1: s = mk(1'b1, 1'b0, ahs_pkg::AHS_EV_FALL, 1'b0); // R1
          4'h2: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_RISE, 1'b1); // R1
          4'h4: s = mk(1'b1, 1'b1, ahs_pkg::AHS_EV_RISE, 1'b0); // R2
          4'h5: s = mk(1'b1, 1'b0, ahs_pkg::AHS_EV_FALL, 1'b0); // R2
          4'h6: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_RISE, 1'b1); // R2
          4'h8: s = mk(1'b1, 1'b0, ahs_pkg::AHS_EV_FALL, 1'b0); // R3
          4'h9: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_RISE, 1'b1); // R3
          default: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_Z, 1'b1);
        endcase
      end
      `AHS_M29: begin
        case (k)
          4'h0: s = mk(1'b0, 1'b1, ahs_pkg::AHS_EV_RISE, 1'b0); // R4
          4'h1: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_FALL, 1'b0); // R4
          4'h2: s = mk(1'b1, 1'b0, ahs_pkg::AHS_EV_RISE, 1'b1); // R4
          4'h4: s = mk(1'b1, 1'b1, ahs_pkg::AHS_EV_RISE, 1'b0); // R5
          4'h5: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_FALL, 1'b0); // R5
          4'h6: s = mk(1'b1, 1'b0, ahs_pkg::AHS_EV_RISE, 1'b1); // R5
          4'h8: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_FALL, 1'b0); // R6
          4'h9: s = mk(1'b1, 1'b0, ahs_pkg::AHS_EV_RISE, 1'b1); // R6
          default: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_Z, 1'b1);
        endcase
      end
      `AHS_M30: begin
        case (k)
          4'h0: s = mk(1'b0, 1'b1, ahs_pkg::AHS_EV_RISE, 1'b0); // R7
          4'h1: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_FALL, 1'b0); // R7
          4'h2: s = mk(1'b1, 1'b0, ahs_pkg::AHS_EV_RISE, 1'b0); // R7
          4'h3: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_FALL, 1'b1); // R7
          4'h4: s = mk(1'b1, 1'b1, ahs_pkg::AHS_EV_RISE, 1'b0); // R8
          4'h5: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_FALL, 1'b1); // R8
          4'h8: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_FALL, 1'b1); // R9
          default: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_Z, 1'b1);
        endcase
      end
      `AHS_M33: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_Z, 1'b1); // R11
      `AHS_M34: s = mk(1'b1, 1'b0, ahs_pkg::AHS_EV_Z, 1'b1); // R12
      `AHS_M_NEG1: begin
        if (i == 2'h0) begin
          s = mk(1'b0, 1'b1, ahs_pkg::AHS_EV_MECH, 1'b0); // R17
        end else begin
          s = mk(1'b1, 1'b0, ahs_pkg::AHS_EV_Z, 1'b1); // R17
        end
      end
      `AHS_M_NEG2: begin
        if (i == 2'h0) begin
          s = mk(1'b1, 1'b1, ahs_pkg::AHS_EV_MECH, 1'b0); // R18
        end else begin
          s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_Z, 1'b1); // R18
        end
      end
      default: s = mk(1'b0, 1'b0, ahs_pkg::AHS_EV_Z, 1'b1);
    endcase
    return s;
  endfunction : step_of

  // Pin synchronisation and edge detection
  ahs_pkg::ahs_pins_t pins_s;
  logic home_d_q;
  logic index_d_q;

  ahs_sync #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .d(pins),
    .q(pins_s)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      home_d_q <= 1'b0;
      index_d_q <= 1'b0;
    end else begin
      home_d_q <= pins_s.home;
      index_d_q <= pins_s.index;
    end
  end

  wire hw_rise = pins_s.home & ~home_d_q;
  wire hw_fall = ~pins_s.home & home_d_q;
  wire z_rise = pins_s.index & ~index_d_q;

  // Command word decode
  logic [15:0] cmd_prev_q;
  wire [15:0] cmd = drive_command_word;
  wire op_en = cmd[`AHS_CMD_SWITCH_ON] & cmd[`AHS_CMD_ENA_VOLT] &
               cmd[`AHS_CMD_QSTOP_N] & cmd[`AHS_CMD_RUN]; // R20
  wire halted = cmd[`AHS_CMD_HALT]; // R21
  wire trigger = op_en & cmd[`AHS_CMD_SETPOINT] & ~cmd_prev_q[`AHS_CMD_SETPOINT]; // R19
  wire setpoint_drop = ~cmd[`AHS_CMD_SETPOINT] & cmd_prev_q[`AHS_CMD_SETPOINT];

  // Method classification
  wire [7:0] meth = homing_method_select;
  wire m_switch = (meth == `AHS_M28) | (meth == `AHS_M29) | (meth == `AHS_M30);
  wire m_index = (meth == `AHS_M33) | (meth == `AHS_M34);
  wire m_mech = (meth == `AHS_M_NEG1) | (meth == `AHS_M_NEG2);
  wire m_here = (meth == `AHS_M35); // R13
  wire m_undef = (meth == `AHS_M31) | (meth == `AHS_M32); // R10
  wire m_valid = (m_switch | m_index | m_mech | m_here) & ~m_undef; // R10

  // Sequencer state
  ahs_pkg::ahs_state_t state_q;
  ahs_pkg::ahs_state_t state_d;
  ahs_pkg::ahs_branch_t br_q;
  ahs_pkg::ahs_branch_t br_d;
  logic [1:0] idx_q;
  logic [1:0] idx_d;
  logic [7:0] meth_q;

  ahs_pkg::ahs_step_t cur;
  assign cur = step_of(meth_q, br_q, idx_q);

  logic mech_det;
  ahs_persist #(
    .N(MECH_PERSIST_CYC)
  ) u_persist (
    .clk(clk),
    .srst(srst),
    .en((state_q == ahs_pkg::AHS_RUN) && (cur.ev == ahs_pkg::AHS_EV_MECH) && !halted),
    .cond(torque_at_limit & speed_near_zero), // R16
    .det_q(mech_det)
  );

  wire moving = (state_q == ahs_pkg::AHS_RUN) & ~halted; // R21
  wire ev_hit = moving & ((cur.ev == ahs_pkg::AHS_EV_RISE) ? hw_rise :
                          (cur.ev == ahs_pkg::AHS_EV_FALL) ? hw_fall :
                          (cur.ev == ahs_pkg::AHS_EV_Z) ? z_rise : mech_det);
  wire lim_travel = cur.fwd ? pins_s.lim_pos : pins_s.lim_neg;
  wire take_branch_b = moving & (meth_q == `AHS_M28 || meth_q == `AHS_M29 ||
                       meth_q == `AHS_M30) & (br_q == ahs_pkg::AHS_BR_A) &
                       (idx_q == 2'h0) & pins_s.lim_neg; // R2 R5 R8
  wire lim_fault = moving & lim_travel & (cur.ev != ahs_pkg::AHS_EV_MECH) & ~take_branch_b;

  always_comb begin
    state_d = state_q;
    br_d = br_q;
    idx_d = idx_q;
    unique case (state_q)
      ahs_pkg::AHS_IDLE, ahs_pkg::AHS_DONE, ahs_pkg::AHS_ERR: begin
        if (trigger) begin
          br_d = (m_switch && pins_s.home) ? ahs_pkg::AHS_BR_C : ahs_pkg::AHS_BR_A; // R3
          idx_d = 2'h0;
          if (!m_valid) begin
            state_d = ahs_pkg::AHS_ERR; // R10
          end else if (m_here) begin
            state_d = ahs_pkg::AHS_DONE; // R13
          end else begin
            state_d = ahs_pkg::AHS_RUN;
          end
        end
      end
      ahs_pkg::AHS_RUN: begin
        if (!op_en || setpoint_drop) begin
          state_d = ahs_pkg::AHS_IDLE; // R20
        end else if (take_branch_b) begin
          br_d = ahs_pkg::AHS_BR_B; // R2 R5 R8
          idx_d = 2'h0;
        end else if (lim_fault) begin
          state_d = ahs_pkg::AHS_ERR;
        end else if (ev_hit) begin
          if (cur.last) begin
            state_d = ahs_pkg::AHS_DONE; // R1 R11 R12
          end else begin
            idx_d = idx_q + 2'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ahs_pkg::AHS_IDLE;
      br_q <= ahs_pkg::AHS_BR_A;
      idx_q <= 2'h0;
      meth_q <= 8'h00;
      cmd_prev_q <= `AHS_CMD_WORD_RST;
    end else begin
      state_q <= state_d;
      br_q <= br_d;
      idx_q <= idx_d;
      cmd_prev_q <= cmd;
      if (trigger) begin
        meth_q <= meth;
      end
    end
  end

  // Motion command for the next cycle
  ahs_pkg::ahs_step_t nxt;
  assign nxt = step_of(meth_q, br_d, idx_d);
  wire [31:0] spd_mag = nxt.fast ? motion_cfg.high_speed : motion_cfg.low_speed; // R23
  wire run_next = (state_d == ahs_pkg::AHS_RUN) & ~halted & (state_q == ahs_pkg::AHS_RUN);
  wire [31:0] speed_d = !run_next ? 32'h0000_0000 :
                        nxt.fwd ? spd_mag : (32'h0000_0000 - spd_mag);

  // Position load at completion
  // Completion from a search or a method 35 trigger, also when already done
  wire done_pulse = (state_d == ahs_pkg::AHS_DONE) & ((state_q == ahs_pkg::AHS_RUN) | trigger);
  wire [31:0] pos_step = actual_position + {{16{enc_delta[15]}}, enc_delta};
  wire [31:0] pos_home = (homing_offset_kind == `AHS_KIND_ABS) ? home_position_offset :
                         (actual_position + home_position_offset); // R14 R15

  // Status word
  wire [15:0] status_d = {
    (state_d == ahs_pkg::AHS_DONE),
    1'b0,
    (state_d == ahs_pkg::AHS_ERR),
    (state_d == ahs_pkg::AHS_DONE),
    1'b0,
    (state_d != ahs_pkg::AHS_RUN) | halted,
    1'b0, 1'b0, 1'b0, 1'b0,
    cmd[`AHS_CMD_QSTOP_N],
    cmd[`AHS_CMD_ENA_VOLT],
    1'b0,
    op_en,
    cmd[`AHS_CMD_SWITCH_ON] & cmd[`AHS_CMD_ENA_VOLT],
    cmd[`AHS_CMD_ENA_VOLT]
  }; // R22

  always_ff @(posedge clk) begin
    if (srst) begin
      speed_cmd <= 32'h0000_0000;
      accel_cmd <= 32'h0000_0000;
      actual_position <= `AHS_POS_RST;
      drive_status_word <= `AHS_STAT_WORD_RST;
      homing_active <= 1'b0;
    end else begin
      speed_cmd <= speed_d; // R21 R23
      accel_cmd <= motion_cfg.accel; // R23
      actual_position <= done_pulse ? pos_home : pos_step;
      drive_status_word <= status_d; // R22
      homing_active <= (state_d == ahs_pkg::AHS_RUN);
    end
  end

  start_run_a: assert property (@(posedge clk) disable iff (srst) // R19
    (state_q != ahs_pkg::AHS_RUN) && trigger && m_valid && !m_here
    |=> (state_q == ahs_pkg::AHS_RUN) && homing_active)
    else $error("trigger did not start homing");

  undef_err_a: assert property (@(posedge clk) disable iff (srst) // R10
    (state_q != ahs_pkg::AHS_RUN) && trigger && m_undef
    |=> drive_status_word[`AHS_ST_ERROR] && !drive_status_word[`AHS_ST_ATTAINED])
    else $error("undefined method not reported as error");

  here_done_a: assert property (@(posedge clk) disable iff (srst) // R13
    (state_q != ahs_pkg::AHS_RUN) && trigger && m_here
    |=> drive_status_word[`AHS_ST_ATTAINED] && (speed_cmd == 32'h0000_0000))
    else $error("method 35 did not complete at once");

  abs_load_a: assert property (@(posedge clk) disable iff (srst) // R14
    done_pulse && (homing_offset_kind == `AHS_KIND_ABS)
    |=> actual_position == $past(home_position_offset))
    else $error("absolute homing position wrong");

  rel_load_a: assert property (@(posedge clk) disable iff (srst) // R15
    done_pulse && (homing_offset_kind == `AHS_KIND_REL)
    |=> actual_position == $past(actual_position) + $past(home_position_offset))
    else $error("relative homing position wrong");

  halt_stop_a: assert property (@(posedge clk) disable iff (srst) // R21
    halted [*2] |-> speed_cmd == 32'h0000_0000)
    else $error("motion not halted");

  qstop_abort_a: assert property (@(posedge clk) disable iff (srst) // R20
    (state_q == ahs_pkg::AHS_RUN) && !cmd[`AHS_CMD_QSTOP_N]
    |=> !homing_active ##1 (speed_cmd == 32'h0000_0000))
    else $error("quick stop did not end homing");

  first_leg_a: assert property (@(posedge clk) disable iff (srst) // R1
    (state_q != ahs_pkg::AHS_RUN) && trigger && (meth == `AHS_M28) && !pins_s.home
    ##1 (state_q == ahs_pkg::AHS_RUN) && !halted && !take_branch_b && !ev_hit && op_en
    && !lim_fault && !setpoint_drop
    |=> speed_cmd == 32'h0000_0000 - motion_cfg.high_speed)
    else $error("method 28 first leg not reverse fast");

  limit_branch_a: assert property (@(posedge clk) disable iff (srst) // R2
    take_branch_b && op_en && !setpoint_drop
    |=> (br_q == ahs_pkg::AHS_BR_B) && (idx_q == 2'h0) && cur.fwd && cur.fast)
    else $error("limit did not reverse the search");

  index_stop_a: assert property (@(posedge clk) disable iff (srst) // R11
    moving && (meth_q == `AHS_M33) && z_rise && op_en && !setpoint_drop && !lim_fault
    |=> drive_status_word[`AHS_ST_ATTAINED])
    else $error("index pulse did not end method 33");

  fwd_index_a: assert property (@(posedge clk) disable iff (srst) // R12
    moving && (meth_q == `AHS_M34) && z_rise && op_en && !setpoint_drop && !lim_fault
    |=> drive_status_word[`AHS_ST_ATTAINED] && (speed_cmd == 32'h0000_0000))
    else $error("index pulse did not end method 34");

  setpoint_abort_a: assert property (@(posedge clk) disable iff (srst) // R19
    (state_q == ahs_pkg::AHS_RUN) && setpoint_drop
    |=> !homing_active && !drive_status_word[`AHS_ST_ATTAINED])
    else $error("set-point drop did not end homing");

endmodule : ahs_sequencer

/* verilog/ahs_params.svh */
// Constants of the axis homing sequencer: offsets, bit positions, codes, timing
//
// Overview of operation
// R1: Method 28, switch off: reverse fast, rise forward slow, fall reverse slow, rise stop.
// R2: Method 28, limit hit: forward fast, rise slow, fall reverse slow, rise stop.
// R3: Method 28, switch on: forward slow, fall reverse slow, rise stop.
// R4: Method 29, switch off: reverse fast, rise reverse slow, fall forward slow, rise stop.
// R5: Method 29, limit hit: forward fast, rise reverse slow, fall forward slow, rise stop.
// R6: Method 29, switch on: reverse slow, fall forward slow, rise stop.
// R7: Method 30, switch off: reverse fast, rise slow, fall forward, rise reverse, fall stop.
// R8: Method 30, limit hit: forward fast, rise reverse slow, fall stop.
// R9: Method 30, switch on: reverse slow, stop at falling edge.
// R10: Methods 31 and 32 are undefined; starting them reports a homing error.
// R11: Method 33: reverse slow, stop at first index pulse.
// R12: Method 34: forward slow, stop at first index pulse.
// R13: Method 35: no motion, present position becomes home at trigger.
// R14: Offset kind 0 loads actual position with the home offset at completion.
// R15: Offset kind 1 adds the home offset to actual position at completion.
// R16: Mechanical limit is torque at limit with near-zero speed, held persistently.
// R17: Method -1: reverse fast to mechanical limit, forward slow, stop at index rise.
// R18: Method -2: forward fast to mechanical limit, reverse slow, stop at index rise.
// R19: Homing starts on command word bit 4 rising, 0x0f to 0x1f.
// R20: Bits 0, 1, 3 high and quick-stop bit 2 high enable operation.
// R21: Command bit 8 high halts motion; low keeps present state.
// R22: Status word bit 12 shows homing attained, bit 13 homing error.
// R23: Search speeds and acceleration come from configured inputs, not constants.
`ifndef AHS_PARAMS_SVH
`define AHS_PARAMS_SVH

`define AHS_CMD_WORD_OFS 16'h6040
`define AHS_STAT_WORD_OFS 16'h6041
`define AHS_CMD_WORD_RST 16'h0000
`define AHS_STAT_WORD_RST 16'h0000
`define AHS_POS_RST 32'h0000_0000

`define AHS_CMD_SWITCH_ON 0
`define AHS_CMD_ENA_VOLT 1
`define AHS_CMD_QSTOP_N 2
`define AHS_CMD_RUN 3
`define AHS_CMD_SETPOINT 4
`define AHS_CMD_HALT 8

`define AHS_ST_READY 0
`define AHS_ST_SWITCHED 1
`define AHS_ST_OP_EN 2
`define AHS_ST_VOLT 4
`define AHS_ST_QSTOP 5
`define AHS_ST_TARGET 10
`define AHS_ST_ATTAINED 12
`define AHS_ST_ERROR 13
`define AHS_ST_FOUND 15

`define AHS_M28 8'h1c
`define AHS_M29 8'h1d
`define AHS_M30 8'h1e
`define AHS_M31 8'h1f
`define AHS_M32 8'h20
`define AHS_M33 8'h21
`define AHS_M34 8'h22
`define AHS_M35 8'h23
`define AHS_M_NEG1 8'hff
`define AHS_M_NEG2 8'hfe

`define AHS_KIND_ABS 1'h0
`define AHS_KIND_REL 1'h1

`define AHS_CLK_HZ 10000000
`define AHS_MECH_PERSIST_MS 10
`define AHS_MECH_PERSIST_CYC ((`AHS_MECH_PERSIST_MS * `AHS_CLK_HZ) / 1000)

`endif

/* verilog/ahs_pkg.sv */
// Types of the axis homing sequencer
package ahs_pkg;

  typedef enum logic [3:0] {
    AHS_IDLE = 4'h1,
    AHS_RUN = 4'h2,
    AHS_DONE = 4'h4,
    AHS_ERR = 4'h8
  } ahs_state_t;

  typedef enum logic [1:0] {
    AHS_EV_RISE = 2'h0,
    AHS_EV_FALL = 2'h1,
    AHS_EV_Z = 2'h2,
    AHS_EV_MECH = 2'h3
  } ahs_ev_t;

  typedef enum logic [1:0] {
    AHS_BR_A = 2'h0,
    AHS_BR_B = 2'h1,
    AHS_BR_C = 2'h2
  } ahs_branch_t;

  typedef struct packed {
    logic fwd;
    logic fast;
    ahs_ev_t ev;
    logic last;
  } ahs_step_t;

  typedef struct packed {
    logic home;
    logic lim_neg;
    logic lim_pos;
    logic index;
  } ahs_pins_t;

  typedef struct packed {
    logic [31:0] high_speed;
    logic [31:0] low_speed;
    logic [31:0] accel;
  } ahs_motion_cfg_t;

endpackage : ahs_pkg

/* verilog/ahs_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module ahs_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : ahs_sync

/* verilog/ahs_persist.sv */
// Persistence filter for the mechanical-limit condition
`timescale 1ns/1ps
module ahs_persist #(
  parameter int N = 100000
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic en,
  input wire logic cond,
  output logic det_q
);

  localparam int CW = $clog2(N + 1);
  localparam logic [CW-1:0] LAST = CW'(N - 1);

  logic [CW-1:0] cnt_q;
  wire hold = en & cond;
  wire reach = hold & (cnt_q == LAST);

  always_ff @(posedge clk) begin
    if (srst || !hold) begin
      cnt_q <= '0;
    end else if (!reach) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      det_q <= 1'b0;
    end else begin
      det_q <= reach; // R16
    end
  end

  persist_held_a: assert property (@(posedge clk) disable iff (srst) // R16
    det_q |-> $past(hold) && ($past(cnt_q) == LAST))
    else $error("mechanical limit flagged without persistence");

endmodule : ahs_persist

/* testbench/ahs_host_model.sv */
// Host controller model that presents the command word
`timescale 1ns/1ps
module ahs_host_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic go,
  input wire logic halt,
  input wire logic quick_stop,
  output logic [15:0] drive_command_word
);
  logic setpoint_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      setpoint_q <= 1'h0;
    end else begin
      setpoint_q <= go;
    end
  end

  // Enabled word is 0x0f; raising the set-point bit makes it 0x1f
  assign drive_command_word = {7'h00, halt, 3'h0, setpoint_q, 1'h1, ~quick_stop, 2'h3};
endmodule : ahs_host_model

/* testbench/axis_homing_sequencer_tb.sv */
// Self-checking bench of the homing sequencer
`timescale 1ns/1ps
`include "ahs_params.svh"
module axis_homing_sequencer_tb;
  localparam logic [31:0] HS = 32'h0000_0100;
  localparam logic [31:0] LS = 32'h0000_0020;
  localparam logic [31:0] NHS = 32'hffff_ff00;
  localparam logic [31:0] NLS = 32'hffff_ffe0;
  localparam ahs_pkg::ahs_pins_t P_OFF = 4'h0;
  localparam ahs_pkg::ahs_pins_t P_HOME = 4'h8;
  localparam ahs_pkg::ahs_pins_t P_LIM = 4'h4;
  localparam ahs_pkg::ahs_pins_t P_IDX = 4'h1;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic go = 1'h0;
  logic halt = 1'h0;
  logic qs = 1'h0;
  logic [15:0] cmd_word;
  logic [15:0] status;
  logic [7:0] method = 8'h00;
  logic kind = 1'h0;
  logic [31:0] offset = 32'h0000_0000;
  ahs_pkg::ahs_motion_cfg_t cfg = '{HS, LS, 32'h0000_0040};
  ahs_pkg::ahs_pins_t pins = 4'h0;
  logic torque = 1'h0;
  logic near_zero = 1'h0;
  logic [31:0] pos;
  logic [31:0] speed;
  logic [31:0] accel;
  logic active;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  ahs_host_model host (.clk(clk), .srst(srst), .go(go), .halt(halt), .quick_stop(qs),
    .drive_command_word(cmd_word));

  ahs_sequencer #(.MECH_PERSIST_CYC(8)) dut (.clk(clk), .srst(srst),
    .drive_command_word(cmd_word), .drive_status_word(status),
    .homing_method_select(method), .homing_offset_kind(kind),
    .home_position_offset(offset), .motion_cfg(cfg), .pins(pins),
    .torque_at_limit(torque), .speed_near_zero(near_zero), .enc_delta(16'h0000),
    .actual_position(pos), .speed_cmd(speed), .accel_cmd(accel), .homing_active(active));

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_flag(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_flag

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : wait_cyc

  // Drop set-point, preset pins and parameters, raise set-point, check first speed
  task automatic start(input logic [7:0] m, input logic k, input logic [31:0] ofs,
                       input logic hm, input logic [31:0] exp);
    go = 1'h0;
    pins = hm ? P_HOME : P_OFF;
    wait_cyc(3);
    method = m;
    kind = k;
    offset = ofs;
    go = 1'h1;
    wait_cyc(8);
    chk(speed, exp, "start speed");
  endtask : start

  task automatic step(input ahs_pkg::ahs_pins_t p, input logic h, input logic t,
                      input logic [31:0] exp);
    pins = p;
    halt = h;
    torque = t;
    near_zero = t;
    wait_cyc(14);
    torque = 1'h0;
    near_zero = 1'h0;
    chk(speed, exp, "step speed");
  endtask : step

  task automatic done_chk(input logic [31:0] exp_pos);
    chk_flag(status[12], 1'h1, "attained");
    chk_flag(status[15], 1'h1, "found");
    chk_flag(status[13], 1'h0, "error");
    chk_flag(active, 1'h0, "active");
    chk(speed, 32'h0000_0000, "stopped");
    chk(pos, exp_pos, "position");
  endtask : done_chk

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("FAIL %0t run did not complete", $time);
      finish_test;
    end
  end

  initial begin
    wait_cyc(2);
    chk({16'h0000, status}, 32'h0000_0000, "status in reset");
    chk(pos, 32'h0000_0000, "position in reset");
    srst = 1'h0;
    wait_cyc(1);
    chk_flag(status[12] | status[13], 1'h0, "no homing result after reset");
    start(`AHS_M33, 1'h0, 32'h0000_1234, 1'h0, NLS);
    chk_flag(active, 1'h1, "searching");
    chk_flag(status[2], 1'h1, "operation enabled");
    step(P_OFF, 1'h1, 1'h0, 32'h0000_0000);
    step(P_OFF, 1'h0, 1'h0, NLS);
    step(P_IDX, 1'h0, 1'h0, 32'h0000_0000);
    done_chk(32'h0000_1234);
    start(`AHS_M34, 1'h1, 32'h0000_1234, 1'h0, LS);
    step(P_IDX, 1'h0, 1'h0, 32'h0000_0000);
    done_chk(32'h0000_2468);
    start(`AHS_M35, 1'h0, 32'h0000_0055, 1'h0, 32'h0000_0000);
    done_chk(32'h0000_0055);
    for (int i = 0; i < 2; i++) begin
      start(i ? `AHS_M32 : `AHS_M31, 1'h0, 32'h0000_0000, 1'h0, 32'h0000_0000);
      chk_flag(status[13], 1'h1, "undefined method");
      chk_flag(status[12], 1'h0, "no attain");
    end
    start(`AHS_M28, 1'h0, 32'h0000_0011, 1'h0, NHS);
    step(P_HOME, 1'h0, 1'h0, LS);
    step(P_OFF, 1'h0, 1'h0, NLS);
    step(P_HOME, 1'h0, 1'h0, 32'h0000_0000);
    done_chk(32'h0000_0011);
    start(`AHS_M28, 1'h0, 32'h0000_0012, 1'h1, LS);
    step(P_OFF, 1'h0, 1'h0, NLS);
    step(P_HOME, 1'h0, 1'h0, 32'h0000_0000);
    start(`AHS_M29, 1'h0, 32'h0000_0022, 1'h0, NHS);
    step(P_LIM, 1'h0, 1'h0, HS);
    step(P_HOME, 1'h0, 1'h0, NLS);
    step(P_OFF, 1'h0, 1'h0, LS);
    step(P_HOME, 1'h0, 1'h0, 32'h0000_0000);
    done_chk(32'h0000_0022);
    start(`AHS_M30, 1'h0, 32'h0000_0031, 1'h0, NHS);
    step(P_HOME, 1'h0, 1'h0, NLS);
    step(P_OFF, 1'h0, 1'h0, LS);
    step(P_HOME, 1'h0, 1'h0, NLS);
    step(P_OFF, 1'h0, 1'h0, 32'h0000_0000);
    start(`AHS_M30, 1'h0, 32'h0000_0033, 1'h1, NLS);
    step(P_OFF, 1'h0, 1'h0, 32'h0000_0000);
    done_chk(32'h0000_0033);
    start(`AHS_M_NEG1, 1'h0, 32'h0000_0044, 1'h0, NHS);
    torque = 1'h1;
    near_zero = 1'h1;
    wait_cyc(4);
    torque = 1'h0;
    near_zero = 1'h0;
    wait_cyc(6);
    chk(speed, NHS, "short stall ignored");
    step(P_OFF, 1'h0, 1'h1, LS);
    step(P_IDX, 1'h0, 1'h0, 32'h0000_0000);
    done_chk(32'h0000_0044);
    start(`AHS_M_NEG2, 1'h0, 32'h0000_0066, 1'h0, HS);
    step(P_OFF, 1'h0, 1'h1, NLS);
    step(P_IDX, 1'h0, 1'h0, 32'h0000_0000);
    done_chk(32'h0000_0066);
    start(`AHS_M34, 1'h0, 32'h0000_0000, 1'h0, LS);
    go = 1'h0;
    wait_cyc(4);
    chk_flag(active, 1'h0, "set-point drop abort");
    start(`AHS_M33, 1'h0, 32'h0000_0000, 1'h0, NLS);
    qs = 1'h1;
    wait_cyc(4);
    chk_flag(active, 1'h0, "quick stop abort");
    chk(speed, 32'h0000_0000, "quick stop speed");
    qs = 1'h1;
    start(`AHS_M33, 1'h0, 32'h0000_0000, 1'h0, 32'h0000_0000);
    chk_flag(active, 1'h0, "refused start");
    chk_flag(status[2], 1'h0, "operation disabled");
    qs = 1'h0;
    chk(accel, 32'h0000_0040, "accel follows config");
    finish_test;
  end
endmodule : axis_homing_sequencer_tb
